/* File: ppmc_map.svh */
// constants for the push-pull mode controller
`ifndef PPMC_MAP_SVH
`define PPMC_MAP_SVH
`define PPMC_CLK_HZ 25000000
`define PPMC_FSW_KHZ 290
`define PPMC_DEAD_NS 85
`define PPMC_PERSIST_MS 120
`define PPMC_SLEEP_MS 840
// half period of the switching cycle, rounded down
`define PPMC_HALF_CYC ((`PPMC_CLK_HZ / 1000) / (2 * `PPMC_FSW_KHZ))
// dead interval: least time, rounded up, at least one cycle
`define PPMC_DEAD_CYC ((`PPMC_DEAD_NS * 25 + 999) / 1000)
`define PPMC_PERSIST_CYC (`PPMC_PERSIST_MS * (`PPMC_CLK_HZ / 1000))
`define PPMC_SLEEP_CYC (`PPMC_SLEEP_MS * (`PPMC_CLK_HZ / 1000))
`endif

/* File: ppmc_pkg.sv */
// types for the push-pull mode controller
package ppmc_pkg;
  typedef enum logic [2:0] {
    PPMC_SOFT = 3'b001,
    PPMC_STEADY = 3'b010,
    PPMC_PROTECT = 3'b100
  } ppmc_mode_t;
  typedef struct packed {
    logic on_a;
    logic on_b;
    logic limit;
  } ppmc_drive_t;
endpackage : ppmc_pkg

/* File: ppmc_phase_gen.sv */
// alternating two-phase gate generator with dead interval
`timescale 1ns/1ps
`include "ppmc_map.svh"
module ppmc_phase_gen #(
  parameter int HALF_CYC = `PPMC_HALF_CYC,
  parameter int DEAD_CYC = `PPMC_DEAD_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic run,
  output logic gate_a,
  output logic gate_b
);
  logic [15:0] cnt_ff, nxt_cnt;
  logic side_ff, nxt_side;
  logic ga_ff, nxt_ga, gb_ff, nxt_gb;

  // each half period: dead interval first, then one side conducts
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_side = side_ff;
    nxt_ga = 1'b0;
    nxt_gb = 1'b0;
    if (!run) begin
      nxt_cnt = 16'h0000;
    end else begin
      if (cnt_ff == 16'(HALF_CYC - 1)) begin
        nxt_cnt = 16'h0000;
        nxt_side = ~side_ff;
      end else begin
        nxt_cnt = cnt_ff + 16'h0001;
      end
      // both off during dead interval, equal on times per side
      if (nxt_cnt >= 16'(DEAD_CYC)) begin
        nxt_ga = ~nxt_side;
        nxt_gb = nxt_side;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt_ff <= 16'h0000;
      side_ff <= 1'b0;
      ga_ff <= 1'b0;
      gb_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      side_ff <= nxt_side;
      ga_ff <= nxt_ga;
      gb_ff <= nxt_gb;
    end
  end

  assign gate_a = ga_ff;
  assign gate_b = gb_ff;
endmodule : ppmc_phase_gen

/* File: ppmc_ctrl.sv */
// mode controller for an integrated push-pull transformer driver
// Behaviour
// - there are exactly three modes: soft start, steady drive and short-circuit protection.
// - soft start is entered whenever the supply comes up, i.e. on reset.
// - in soft start both switches are driven in the current-limited condition.
// - in soft start, a drain above threshold held longer than the persistence delay leads to protection.
// - in soft start, both drains below threshold lead to steady drive.
// - in steady drive the switches are driven fully on during their phases.
// - in steady drive, either drain above threshold returns the controller to soft start.
// - entering protection stops switching and starts the sleep timer.
// - when the sleep timer reaches the sleep period, soft start is entered again.
// - soft start and protection alternate while a short lasts, and steady drive follows on its own once it clears.
// - switches turn on alternately with equal phases, a dead interval between, at the nominal frequency.
`timescale 1ns/1ps
`include "ppmc_map.svh"
module ppmc_ctrl #(
  parameter int PERSIST_CYC = `PPMC_PERSIST_CYC,
  parameter int SLEEP_CYC = `PPMC_SLEEP_CYC,
  parameter int HALF_CYC = `PPMC_HALF_CYC,
  parameter int DEAD_CYC = `PPMC_DEAD_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic switch_a_drain,
  input wire logic switch_b_drain,
  output logic gate_a,
  output logic gate_b,
  output logic current_limit,
  output ppmc_pkg::ppmc_mode_t mode
);
  logic [1:0] a_sync_ff, b_sync_ff;
  logic high_a, high_b, any_high;
  ppmc_pkg::ppmc_mode_t mode_ff, nxt_mode;
  logic [31:0] tmr_ff, nxt_tmr;
  ppmc_pkg::ppmc_drive_t drv_ff, nxt_drv;
  logic gen_a, gen_b, run;

  // mode test used only by the limit output; the switching enable tests for protect
  function automatic logic ppmc_is_soft(input ppmc_pkg::ppmc_mode_t m);
    return (m == ppmc_pkg::PPMC_SOFT);
  endfunction : ppmc_is_soft

  // two-stage synchronisers; only the second stage is read by logic,
  // so a metastable first stage never reaches the mode decision
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      a_sync_ff <= 2'b00;
      b_sync_ff <= 2'b00;
    end else begin
      a_sync_ff <= {a_sync_ff[0], switch_a_drain};
      b_sync_ff <= {b_sync_ff[0], switch_b_drain};
    end
  end

  assign high_a = a_sync_ff[1];
  assign high_b = b_sync_ff[1];
  assign any_high = high_a | high_b;

  // switching runs in soft start and steady drive, never in protection
  assign run = (mode_ff != ppmc_pkg::PPMC_PROTECT);

  ppmc_phase_gen #(
    .HALF_CYC(HALF_CYC),
    .DEAD_CYC(DEAD_CYC)
  ) u_phase (
    .mclk(mclk),
    .resetn(resetn),
    .run(run),
    .gate_a(gen_a),
    .gate_b(gen_b)
  );

  // mode sequencing; one shared timer serves persistence and sleep
  always_comb begin
    nxt_mode = mode_ff;
    nxt_tmr = tmr_ff;
    unique case (mode_ff)
      ppmc_pkg::PPMC_SOFT: begin
        if (!any_high) begin
          nxt_mode = ppmc_pkg::PPMC_STEADY;
          nxt_tmr = 32'h0;
        end else if (tmr_ff >= 32'(PERSIST_CYC)) begin
          // held longer than the delay: go to sleep
          nxt_mode = ppmc_pkg::PPMC_PROTECT;
          nxt_tmr = 32'h0;
        end else begin
          nxt_tmr = tmr_ff + 32'h1;
        end
      end
      ppmc_pkg::PPMC_STEADY: begin
        nxt_tmr = 32'h0;
        if (any_high) begin
          nxt_mode = ppmc_pkg::PPMC_SOFT;
        end
      end
      ppmc_pkg::PPMC_PROTECT: begin
        if (tmr_ff >= 32'(SLEEP_CYC - 1)) begin
          nxt_mode = ppmc_pkg::PPMC_SOFT;
          nxt_tmr = 32'h0;
        end else begin
          nxt_tmr = tmr_ff + 32'h1;
        end
      end
      default: begin
        // illegal one-hot code recovers through soft start
        nxt_mode = ppmc_pkg::PPMC_SOFT;
        nxt_tmr = 32'h0;
      end
    endcase
  end

  // drive outputs registered; limit follows the present mode, one cycle late,
  // in step with the gates which are also qualified by the present mode
  always_comb begin
    nxt_drv.on_a = gen_a & run;
    nxt_drv.on_b = gen_b & run;
    nxt_drv.limit = ppmc_is_soft(mode_ff);
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mode_ff <= ppmc_pkg::PPMC_SOFT;
      tmr_ff <= 32'h0;
      drv_ff <= '{on_a: 1'b0, on_b: 1'b0, limit: 1'b1};
    end else begin
      mode_ff <= nxt_mode;
      tmr_ff <= nxt_tmr;
      drv_ff <= nxt_drv;
    end
  end

  assign gate_a = drv_ff.on_a;
  assign gate_b = drv_ff.on_b;
  assign current_limit = drv_ff.limit;
  assign mode = mode_ff;
endmodule : ppmc_ctrl

/* File: ppmc_chk.sv */
// port assertions for the mode controller
`timescale 1ns/1ps
`include "ppmc_map.svh"
module ppmc_chk #(parameter int SLEEP_CYC = `PPMC_SLEEP_CYC) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic switch_a_drain,
  input wire logic switch_b_drain,
  input wire logic gate_a,
  input wire logic gate_b,
  input wire logic current_limit,
  input wire ppmc_pkg::ppmc_mode_t mode
);
  logic [31:0] prot_cnt;

  // counts protect cycles, so the sleep length needs no long delay in a property
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prot_cnt <= 32'h0;
    end else if (mode[2]) begin
      prot_cnt <= prot_cnt + 32'h1;
    end else begin
      prot_cnt <= 32'h0;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // mode bits: 0 soft, 1 steady, 2 protect
  sequence s_low; (mode[0] && !switch_a_drain && !switch_b_drain) [*4]; endsequence
  sequence s_woke; mode[0] && (prot_cnt == 32'(SLEEP_CYC)); endsequence
  property p_hot; $onehot(mode); endproperty
  property p_rst; disable iff (1'b0) !resetn |=> mode[0] && current_limit && !gate_a && !gate_b; endproperty
  property p_lim; mode[0] |=> current_limit; endproperty
  property p_full; mode[1] |=> !current_limit; endproperty
  property p_up; s_low |=> mode[1]; endproperty
  property p_back; mode[1] && (switch_a_drain || switch_b_drain) |-> ##[1:4] mode[0]; endproperty
  property p_stop; mode[2] |=> !gate_a && !gate_b; endproperty
  property p_sleep; $fell(mode[2]) |-> s_woke; endproperty
  property p_entry; $rose(mode[2]) |-> $past(mode[0]); endproperty
  property p_ovl; !(gate_a && gate_b); endproperty
  // a missing dead interval would let both switches conduct at once
  property p_dead; $fell(gate_a) |-> !gate_b [*3]; endproperty
  a_hot: assert property (p_hot) else $error("mode not one-hot");
  a_rst: assert property (p_rst) else $error("reset state");
  a_lim: assert property (p_lim) else $error("no limit in soft");
  a_full: assert property (p_full) else $error("limit in steady");
  a_up: assert property (p_up) else $error("no steady");
  a_back: assert property (p_back) else $error("no return to soft");
  a_stop: assert property (p_stop) else $error("gates in protect");
  a_sleep: assert property (p_sleep) else $error("sleep length");
  a_entry: assert property (p_entry) else $error("protect not entered from soft");
  a_ovl: assert property (p_ovl) else $error("gates overlap");
  a_dead: assert property (p_dead) else $error("dead interval");
endmodule : ppmc_chk
bind ppmc_ctrl ppmc_chk #(.SLEEP_CYC(SLEEP_CYC)) ppmc_chk_inst (.mclk(mclk), .resetn(resetn),
  .switch_a_drain(switch_a_drain), .switch_b_drain(switch_b_drain), .gate_a(gate_a), .gate_b(gate_b),
  .current_limit(current_limit), .mode(mode));

/* File: ppmc_load.sv */
// transformer primary seen through the drain comparators
`timescale 1ns/1ps
module ppmc_load (
  input wire logic shorted,
  output logic switch_a_drain,
  output logic switch_b_drain
);
  // a shorted secondary keeps both drains above threshold; no slow charge is modelled
  assign switch_a_drain = shorted;
  assign switch_b_drain = shorted;
endmodule : ppmc_load

/* File: ppmc_tb.sv */
// testbench for the mode controller with its load model
`timescale 1ns/1ps
module testbench;
  logic mclk = 0, resetn = 0, shorted = 0, sa, sb, ga, gb, cl;
  ppmc_pkg::ppmc_mode_t md;
  int num_errors = 0, n_checks = 0, k;
  always #20 mclk = ~mclk;
  ppmc_ctrl #(.PERSIST_CYC(20), .SLEEP_CYC(50)) ppmc_ctrl_inst (.mclk(mclk), .resetn(resetn),
    .switch_a_drain(sa), .switch_b_drain(sb), .gate_a(ga), .gate_b(gb), .current_limit(cl), .mode(md));
  ppmc_load ppmc_load_inst (.shorted(shorted), .switch_a_drain(sa), .switch_b_drain(sb));
  task automatic chk(logic [7:0] got, logic [7:0] exp, string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk
  // inputs change 1 ns after the edge, outputs are settled then
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic t_start;
    chk({5'h0, md}, 8'h01, "soft after reset");
    chk({7'h0, cl}, 8'h01, "limit");
    tick(6);
    chk({5'h0, md}, 8'h02, "steady");
    chk({7'h0, cl}, 8'h00, "full drive");
    k = 0;
    while (gb !== 1'b1 && k < 100) begin
      tick(1);
      k++;
    end
    k = 0;
    while (gb === 1'b1 && k < 100) begin
      tick(1);
      k++;
    end
    chk(8'(k), 8'h28, "phase width");
    k = 0;
    while (ga !== 1'b1 && k < 100) begin
      tick(1);
      k++;
    end
    chk(8'(k), 8'h03, "dead cycles");
    $display("t_start done");
  endtask : t_start
  task automatic t_short;
    shorted = 1;
    tick(5);
    chk({5'h0, md}, 8'h01, "back to soft");
    tick(15);
    chk({5'h0, md}, 8'h01, "early protect");
    tick(8);
    chk({5'h0, md}, 8'h04, "protect");
    chk({6'h0, ga, gb}, 8'h00, "gates off");
    tick(45);
    chk({5'h0, md}, 8'h04, "sleep too short");
    tick(10);
    chk({5'h0, md}, 8'h01, "soft again");
    shorted = 0;
    tick(8);
    chk({5'h0, md}, 8'h02, "recovered");
    $display("t_short done");
  endtask : t_short
  task automatic results;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  // watchdog: the tests need a few hundred cycles
  initial begin
    repeat (3000) @(posedge mclk);
    num_errors++;
    results();
  end
  initial begin
    tick(2);
    resetn = 1;
    t_start();
    t_short();
    results();
  end
endmodule : testbench
